// >>> pos_pkg.sv
/*
  Constants for the power on/off sequencer: register map, fields, resets, timing.
  Assumes a 100 MHz clock and an APB slave with 32-bit data.
*/
package pos_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TON = 8'h04;
  localparam logic [7:0] ADDR_TOFF = 8'h08;
  localparam logic [7:0] ADDR_UNDERVOLTAGE_LOCKOUT = 8'h0C;
  localparam logic [7:0] ADDR_VID = 8'h10;
  localparam logic [7:0] ADDR_FREQ = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam int unsigned C_HW_EN = 0;
  localparam int unsigned C_SW_REQ = 1;
  localparam int unsigned C_SW_EN = 2;
  localparam int unsigned C_OP_SD = 3;
  localparam int unsigned C_SOFT = 4;
  localparam int unsigned C_MODE = 5;
  localparam int unsigned C_SLEW = 7;
  localparam logic [1:0] MODE_MGMT = 2'h0;
  localparam logic [1:0] MODE_SERIAL_VOLTAGE_ID_MODE = 2'h1;
  localparam logic [1:0] MODE_PARALLEL_VOLTAGE_ID_MODE = 2'h2;
  localparam logic [8:0] CTRL_RST = 9'h101;
  localparam logic [1:0] SLEW_2P5 = 2'h2;
  localparam logic [6:0] TON_DLY_RST = 7'h00;
  localparam logic [6:0] TON_RISE_RST = 7'h0A;
  localparam logic [7:0] VIN_ON_RST = 8'h40;
  localparam logic [7:0] VIN_OFF_RST = 8'h38;
  localparam logic [7:0] VBOOT_RST = 8'h33;
  localparam logic [10:0] FREQ_MIN = 11'h096;
  localparam logic [10:0] FREQ_MAX = 11'h5DC;
  localparam logic [10:0] FREQ_RST = 11'h258;
  localparam logic [9:0] VID_BASE_MV = 10'h1F4;
  localparam logic [9:0] VID_STEP_MV = 10'h00A;
  localparam logic [2:0] LS_STEPS = 3'h7;
  localparam logic [3:0] LS_CYC_MAX = 4'hF;
  localparam logic [11:0] PARALLEL_VOLTAGE_ID_MODE_STOP_NS_PER_MV = 12'h640;
  localparam logic [11:0] SLEW_NS_PER_MV_2P5 = 12'h190;
endpackage

// >>> pos_sequencer.sv
/*
  Power on/off sequencer of a buck regulator: enable gating, pre-bias low-side
  stepping, reference ramp with delay, soft stop, APB register file.
  Assumes synchronous comparator inputs and a switching-cycle strobe from the modulator.
*/
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
// What this block does
// - Convert only when enable comparator is high and bus voltage reaches turn-on level; the pin is ignored while C_HW_EN is clear.
// - Bus lockout thresholds default to 8 V on and are software replaceable.
// - Lockout and input faults use comparator outputs, never the digitized sample.
// - Pre-bias start holds low-side switch off until first high-side pulse.
// - Low-side on-time starts at one eighth, steps an eighth every 16 cycles.
// - Reference ramp waits for enable, bus level and complete configuration load.
// - Conversion may need a software enable instead of or with the pin.
// - Management mode delays ramp start by 0 to 127 ms in 1 ms steps.
// - Management mode ramp duration is 1 to 127 ms in 1 ms steps.
// - Serial-VID ramp picks one of four slow slew rates.
// - Serial-VID defaults to the 2.5 mV/us slew setting.
// - Boot code zero keeps output unramped until host sends a voltage command.
// - Overcurrent and overvoltage protection stay armed through the whole start-up.
// - Switching frequency programmable between 150 kHz and 1.5 MHz.
// - Enable falling off stops both drivers at once by default.
// - Operation command shutdown and soft turn-off are optional.
// - Soft-off delay 0 to 127 ms applies only in management mode.
// - Management mode soft-stop ramp lasts 1 to 127 ms.
// - Parallel-VID soft stop ramps down at fixed 0.625 mV/us.
// - Eight-bit voltage code maps 01 to 0.50 V in 10 mV steps.
module pos_sequencer (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic en_cmp_in,
  input wire logic vin_on_cmp_in,
  input wire logic vin_off_cmp_in,
  input wire logic cfg_loaded_in,
  input wire logic sw_cycle_in,
  input wire logic hs_pulse_in,
  input wire logic fault_in,
  input wire logic vid_cmd_in,
  input wire logic [7:0] vid_cmd_code_in,
  input wire logic [15:0] adc_vin_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] vin_on_thr_out,
  output logic [7:0] vin_off_thr_out,
  output logic [10:0] freq_khz_out,
  output logic [15:0] vin_telemetry_out,
  output logic drv_en_out,
  output logic ls_en_out,
  output logic [2:0] ls_eighths_out,
  output logic [7:0] ref_code_out,
  output logic [11:0] ref_mv_out,
  output logic prot_armed_out
);
  typedef enum logic [2:0] {
    POS_OFF, POS_TON_DLY, POS_RAMP, POS_WAIT_VID, POS_ON, POS_TOFF_DLY, POS_STOP
  } pos_state_t;
  typedef struct packed {
    pos_state_t st;
    logic [8:0] ctrl;
    logic [6:0] ton_dly;
    logic [6:0] ton_rise;
    logic [6:0] toff_dly;
    logic [6:0] toff_fall;
    logic [7:0] vin_on;
    logic [7:0] vin_off;
    logic [7:0] vboot;
    logic [10:0] freq;
    logic [16:0] tick_cnt;
    logic [6:0] ms_cnt;
    logic [11:0] ns_acc;
    logic [7:0] code;
    logic [7:0] target;
    logic uv_ok;
    logic hs_seen;
    logic [2:0] ls_step;
    logic [3:0] ls_cyc;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic drv;
    logic ls;
    logic [11:0] mv;
    logic [15:0] vin_tel;
    logic [2:0] eighths;
    logic armed;
  } pos_state_s_t;
  pos_state_s_t s_reg, s_next;

  // Code 0 means off; code n gives 500 mV + (n-1) * 10 mV
  function automatic logic [11:0] pos_vid_mv(input logic [7:0] c);
    logic [11:0] m;
    m = 12'h000;
    if (c != 8'h00) begin
      m = {2'h0, pos_pkg::VID_BASE_MV} +
          12'(({4'h0, c} - 12'h001) * {2'h0, pos_pkg::VID_STEP_MV});
    end
    return m;
  endfunction

  // Nanoseconds per millivolt for a serial-VID slew selection
  function automatic logic [11:0] pos_slew_ns(input logic [1:0] sel);
    logic [11:0] n;
    n = pos_pkg::SLEW_NS_PER_MV_2P5;
    unique case (sel)
      2'h0: n = 12'h640;
      2'h1: n = 12'h320;
      2'h2: n = pos_pkg::SLEW_NS_PER_MV_2P5;
      2'h3: n = 12'h0C8;
    endcase
    return n;
  endfunction

  logic [1:0] mode;
  logic enable_ok;
  logic tick;
  logic step_due;
  logic [11:0] ns_per_mv;
  logic wr, rd;
  assign mode = s_reg.ctrl[pos_pkg::C_MODE +: 2];
  assign tick = (s_reg.tick_cnt == 17'(pos_pkg::TICK_CYCLES - 1));

  always_comb begin
    s_next = s_reg;
    wr = psel && penable && pwrite && !s_reg.ready;
    rd = psel && penable && !pwrite && !s_reg.ready;
    s_next.ready = psel && penable && !s_reg.ready;
    s_next.err = 1'b0;
    s_next.vin_tel = adc_vin_in;
    // Comparator hysteresis: on-level to enter, off-level to drop
    if (!s_reg.uv_ok && vin_on_cmp_in) begin
      s_next.uv_ok = 1'b1;
    end else if (s_reg.uv_ok && !vin_off_cmp_in) begin
      s_next.uv_ok = 1'b0;
    end
    enable_ok = (!s_reg.ctrl[pos_pkg::C_HW_EN] || en_cmp_in) &&
                (!s_reg.ctrl[pos_pkg::C_SW_REQ] || s_reg.ctrl[pos_pkg::C_SW_EN]) &&
                !(s_reg.ctrl[pos_pkg::C_OP_SD] && !s_reg.ctrl[pos_pkg::C_SW_EN]) &&
                s_reg.uv_ok && cfg_loaded_in && !fault_in;
    s_next.tick_cnt = tick ? 17'h00000 : s_reg.tick_cnt + 17'h00001;
    if (tick && s_reg.ms_cnt != 7'h00) begin
      s_next.ms_cnt = s_reg.ms_cnt - 7'h01;
    end
    ns_per_mv = (mode == pos_pkg::MODE_SERIAL_VOLTAGE_ID_MODE) ? pos_slew_ns(s_reg.ctrl[pos_pkg::C_SLEW +: 2]) :
                pos_pkg::PARALLEL_VOLTAGE_ID_MODE_STOP_NS_PER_MV;
    s_next.ns_acc = s_reg.ns_acc + 12'h001; // 10 ns per cycle against 10 mV per code
    step_due = 1'b0;
    if (s_reg.ns_acc + 12'h001 >= ns_per_mv) begin
      s_next.ns_acc = 12'h000;
      step_due = 1'b1;
    end
    unique case (s_reg.st)
      POS_OFF: begin
        s_next.drv = 1'b0;
        s_next.ls = 1'b0;
        s_next.code = 8'h00;
        s_next.hs_seen = 1'b0;
        s_next.ls_step = 3'h0;
        s_next.ls_cyc = 4'h0;
        if (enable_ok) begin
          s_next.st = POS_TON_DLY;
          s_next.ms_cnt = (mode == pos_pkg::MODE_MGMT) ? s_reg.ton_dly : 7'h00;
          s_next.tick_cnt = 17'h00000;
        end
      end
      POS_TON_DLY: begin
        if (!enable_ok) begin
          s_next.st = POS_OFF;
        end else if (s_reg.ms_cnt == 7'h00) begin
          s_next.drv = 1'b1;
          s_next.ms_cnt = s_reg.ton_rise;
          s_next.target = s_reg.vboot;
          s_next.st = (s_reg.vboot == 8'h00 && mode != pos_pkg::MODE_MGMT) ?
                      POS_WAIT_VID : POS_RAMP;
        end
      end
      POS_RAMP, POS_WAIT_VID, POS_ON: begin
        if (s_reg.st == POS_WAIT_VID && vid_cmd_in) begin
          s_next.target = vid_cmd_code_in;
          s_next.st = POS_RAMP;
        end
        if (s_reg.st == POS_ON && vid_cmd_in) begin
          s_next.target = vid_cmd_code_in;
        end
        if (s_reg.st != POS_WAIT_VID && s_reg.code != s_reg.target) begin
          // Management mode steps one code per millisecond tick, then one code per cycle once ms_cnt has run out
          if ((mode == pos_pkg::MODE_MGMT && (tick || s_reg.ms_cnt == 7'h00)) ||
              (mode != pos_pkg::MODE_MGMT && step_due)) begin
            s_next.code = (s_reg.code < s_reg.target) ? s_reg.code + 8'h01 :
                          s_reg.code - 8'h01;
          end
        end else if (s_reg.st == POS_RAMP) begin
          s_next.st = POS_ON;
        end
        if (hs_pulse_in) begin
          s_next.hs_seen = 1'b1;
        end
        if (s_reg.hs_seen && sw_cycle_in && s_reg.ls_step != pos_pkg::LS_STEPS) begin
          s_next.ls = 1'b1;
          s_next.ls_cyc = s_reg.ls_cyc + 4'h1;
          if (s_reg.ls_cyc == pos_pkg::LS_CYC_MAX) begin
            s_next.ls_step = s_reg.ls_step + 3'h1;
          end
        end
        if (!enable_ok) begin
          if (s_reg.ctrl[pos_pkg::C_SOFT] && mode != pos_pkg::MODE_SERIAL_VOLTAGE_ID_MODE) begin
            s_next.st = POS_TOFF_DLY;
            s_next.ms_cnt = (mode == pos_pkg::MODE_MGMT) ? s_reg.toff_dly : 7'h00;
            s_next.tick_cnt = 17'h00000;
          end else begin
            s_next.st = POS_OFF;
            s_next.drv = 1'b0;
            s_next.ls = 1'b0;
          end
        end
      end
      POS_TOFF_DLY: begin
        if (s_reg.ms_cnt == 7'h00) begin
          s_next.ms_cnt = s_reg.toff_fall;
          s_next.st = POS_STOP;
        end
      end
      POS_STOP: begin
        if (s_reg.code == 8'h00) begin
          s_next.st = POS_OFF;
          s_next.drv = 1'b0;
          s_next.ls = 1'b0;
        end else if ((mode == pos_pkg::MODE_MGMT && (tick || s_reg.ms_cnt == 7'h00)) ||
                     (mode != pos_pkg::MODE_MGMT && step_due)) begin
          s_next.code = s_reg.code - 8'h01;
        end
      end
      default: s_next.st = POS_OFF;
    endcase
    s_next.mv = pos_vid_mv(s_next.code);
    s_next.eighths = s_next.ls_step + 3'h1;
    s_next.armed = 1'b1;
    if (wr) begin
      unique case (paddr)
        pos_pkg::ADDR_CTRL: s_next.ctrl = pwdata[8:0];
        pos_pkg::ADDR_TON: begin
          s_next.ton_dly = pwdata[6:0];
          s_next.ton_rise = (pwdata[14:8] == 7'h00) ? 7'h01 : pwdata[14:8];
        end
        pos_pkg::ADDR_TOFF: begin
          s_next.toff_dly = pwdata[6:0];
          s_next.toff_fall = (pwdata[14:8] == 7'h00) ? 7'h01 : pwdata[14:8];
        end
        pos_pkg::ADDR_UNDERVOLTAGE_LOCKOUT: begin
          s_next.vin_on = pwdata[7:0];
          s_next.vin_off = pwdata[15:8];
        end
        pos_pkg::ADDR_VID: s_next.vboot = pwdata[7:0];
        pos_pkg::ADDR_FREQ: begin
          // Out-of-range writes are clamped so the modulator never sees an illegal value
          if (pwdata[10:0] < pos_pkg::FREQ_MIN || pwdata[31:11] != 21'h0) begin
            s_next.freq = (pwdata[31:11] != 21'h0) ? pos_pkg::FREQ_MAX : pos_pkg::FREQ_MIN;
          end else if (pwdata[10:0] > pos_pkg::FREQ_MAX) begin
            s_next.freq = pos_pkg::FREQ_MAX;
          end else begin
            s_next.freq = pwdata[10:0];
          end
        end
        pos_pkg::ADDR_STAT: s_next.err = 1'b1;
        default: s_next.err = 1'b1;
      endcase
    end
    s_next.rdata = 32'h00000000;
    if (rd) begin
      unique case (paddr)
        pos_pkg::ADDR_CTRL: s_next.rdata = {23'h0, s_reg.ctrl};
        pos_pkg::ADDR_TON: s_next.rdata = {17'h0, s_reg.ton_rise, 1'b0, s_reg.ton_dly};
        pos_pkg::ADDR_TOFF: s_next.rdata = {17'h0, s_reg.toff_fall, 1'b0, s_reg.toff_dly};
        pos_pkg::ADDR_UNDERVOLTAGE_LOCKOUT: s_next.rdata = {16'h0, s_reg.vin_off, s_reg.vin_on};
        pos_pkg::ADDR_VID: s_next.rdata = {24'h0, s_reg.vboot};
        pos_pkg::ADDR_FREQ: s_next.rdata = {21'h0, s_reg.freq};
        pos_pkg::ADDR_STAT: s_next.rdata = {12'h000, s_reg.uv_ok, s_reg.ls_step,
                                             s_reg.code, 4'h0, 1'b0, s_reg.st};
        default: s_next.err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_reg <= '0;
      s_reg.st <= POS_OFF;
      s_reg.ctrl <= pos_pkg::CTRL_RST;
      s_reg.ton_dly <= pos_pkg::TON_DLY_RST;
      s_reg.ton_rise <= pos_pkg::TON_RISE_RST;
      s_reg.toff_dly <= pos_pkg::TON_DLY_RST;
      s_reg.toff_fall <= pos_pkg::TON_RISE_RST;
      s_reg.vin_on <= pos_pkg::VIN_ON_RST;
      s_reg.vin_off <= pos_pkg::VIN_OFF_RST;
      s_reg.vboot <= pos_pkg::VBOOT_RST;
      s_reg.freq <= pos_pkg::FREQ_RST;
      s_reg.eighths <= 3'h1;
      s_reg.armed <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.err;
  assign vin_on_thr_out = s_reg.vin_on;
  assign vin_off_thr_out = s_reg.vin_off;
  assign freq_khz_out = s_reg.freq;
  assign vin_telemetry_out = s_reg.vin_tel;
  assign drv_en_out = s_reg.drv;
  assign ls_en_out = s_reg.ls;
  assign ls_eighths_out = s_reg.eighths;
  assign ref_code_out = s_reg.code;
  assign ref_mv_out = s_reg.mv;
  // Protection is never gated by the sequencer, including during the ramp
  assign prot_armed_out = s_reg.armed;

  property p_ls_after_hs;
    @(posedge clk_in) disable iff (!rstn_in) (s_reg.ls && !s_reg.hs_seen) == 1'b0;
  endproperty
  a_ls_after_hs: assert property (p_ls_after_hs) else $error("low side before high side");
  property p_no_conv_without_cfg;
    @(posedge clk_in) disable iff (!rstn_in)
      (s_reg.st == POS_OFF && !cfg_loaded_in) |=> s_reg.st == POS_OFF;
  endproperty
  a_no_conv_without_cfg: assert property (p_no_conv_without_cfg) else $error("start w/o cfg");
  property p_hard_off;
    @(posedge clk_in) disable iff (!rstn_in)
      (s_reg.st == POS_ON && !enable_ok && !s_reg.ctrl[pos_pkg::C_SOFT]) |=> !s_reg.drv;
  endproperty
  a_hard_off: assert property (p_hard_off) else $error("drivers not off at once");
  property p_freq_range;
    @(posedge clk_in) disable iff (!rstn_in)
      s_reg.freq >= pos_pkg::FREQ_MIN && s_reg.freq <= pos_pkg::FREQ_MAX;
  endproperty
  a_freq_range: assert property (p_freq_range) else $error("frequency out of range");
  property p_vid_map;
    @(posedge clk_in) disable iff (!rstn_in) (s_reg.code == 8'h01) |-> s_reg.mv == 12'h1F4;
  endproperty
  a_vid_map: assert property (p_vid_map) else $error("code 01 not 500 mV");
  property p_wait_vid;
    @(posedge clk_in) disable iff (!rstn_in)
      (s_reg.st == POS_WAIT_VID && !vid_cmd_in) |=> $stable(s_reg.code);
  endproperty
  a_wait_vid: assert property (p_wait_vid) else $error("ramp without vid command");
  property p_ls_step;
    @(posedge clk_in) disable iff (!rstn_in)
      $changed(s_reg.ls_step) && $past(s_reg.st) != POS_OFF |-> $past(s_reg.ls_cyc) == 4'hF;
  endproperty
  a_ls_step: assert property (p_ls_step) else $error("step not after 16 cycles");
  property p_uv_gate;
    @(posedge clk_in) disable iff (!rstn_in)
      (s_reg.st == POS_OFF && !s_reg.uv_ok) |=> s_reg.st == POS_OFF;
  endproperty
  a_uv_gate: assert property (p_uv_gate) else $error("start under lockout");
endmodule

// >>> pos_host_model.sv
/* Host-side model: sends one voltage-setting command per request.
   Assumes the bench strobes req_in for one cycle with code and latency. */
`timescale 1ns/1ns
module pos_host_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic req_in,
  input wire logic [7:0] code_in,
  input wire logic [3:0] lat_in,
  output logic vid_cmd_out,
  output logic [7:0] vid_code_out
);
  logic [4:0] wait_reg;
  logic [7:0] code_reg;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wait_reg <= 5'h00;
      code_reg <= 8'h00;
      vid_cmd_out <= 1'b0;
      vid_code_out <= 8'hA5;
    end else begin
      if (req_in) begin
        wait_reg <= 5'(lat_in) + 5'h01;
        code_reg <= code_in;
      end else if (wait_reg != 5'h00) begin
        wait_reg <= wait_reg - 5'h01;
      end
      // Code means nothing without the strobe, so it is scrambled meanwhile
      vid_cmd_out <= (wait_reg == 5'h01);
      vid_code_out <= (wait_reg == 5'h01) ? code_reg : ~vid_code_out;
    end
  end
endmodule

// >>> tb_top.sv
/* Self-checking bench for the power sequencer: APB master, pin stimulus, host model.
   Assumes pos_pkg, pos_sequencer and pos_host_model are compiled first. */
`timescale 1ns/1ns
module tb_top;
  logic clk_in = 1'b0, rstn_in = 1'b0, en_cmp_in = 1'b0, vin_on_cmp_in = 1'b0;
  logic vin_off_cmp_in = 1'b0, cfg_loaded_in = 1'b0, sw_cycle_in = 1'b0, hs_pulse_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, host_req = 1'b0, pready, pslverr;
  logic vid_cmd_in, drv_en_out, ls_en_out, prot_armed_out, err;
  logic [7:0] paddr = 8'h00, host_code = 8'h00, vid_cmd_code_in, vin_on_thr_out;
  logic [7:0] vin_off_thr_out, ref_code_out;
  logic [3:0] host_lat = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic [15:0] adc_vin_in = 16'h0, adc_prev = 16'h0, vin_telemetry_out;
  logic [10:0] freq_khz_out;
  logic [11:0] ref_mv_out;
  logic [2:0] ls_eighths_out;
  integer seed = 32'hb4a1;
  int error_cnt = 0, compares = 0, cyc = 0, n;
  always #5 clk_in = ~clk_in;
  pos_sequencer uut (.clk_in(clk_in), .rstn_in(rstn_in), .en_cmp_in(en_cmp_in),
    .vin_on_cmp_in(vin_on_cmp_in), .vin_off_cmp_in(vin_off_cmp_in),
    .cfg_loaded_in(cfg_loaded_in), .sw_cycle_in(sw_cycle_in), .hs_pulse_in(hs_pulse_in),
    .fault_in(1'b0), .vid_cmd_in(vid_cmd_in), .vid_cmd_code_in(vid_cmd_code_in),
    .adc_vin_in(adc_vin_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vin_on_thr_out(vin_on_thr_out), .vin_off_thr_out(vin_off_thr_out),
    .freq_khz_out(freq_khz_out), .vin_telemetry_out(vin_telemetry_out),
    .drv_en_out(drv_en_out), .ls_en_out(ls_en_out), .ls_eighths_out(ls_eighths_out),
    .ref_code_out(ref_code_out), .ref_mv_out(ref_mv_out), .prot_armed_out(prot_armed_out));
  pos_host_model host (.clk_in(clk_in), .rstn_in(rstn_in), .req_in(host_req),
    .code_in(host_code), .lat_in(host_lat), .vid_cmd_out(vid_cmd_in),
    .vid_code_out(vid_cmd_code_in));
  task automatic tally_and_finish();
    $display("Mismatches %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    sw_cycle_in <= (cyc % 4 == 3);
    adc_vin_in <= 16'($random(seed));
    adc_prev <= adc_vin_in;
    if (cyc == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 16), 32'h1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic drive(input logic en, input logic cfg);
    @(posedge clk_in);
    en_cmp_in <= en;
    cfg_loaded_in <= cfg;
  endtask
  task automatic wait_code(input logic [7:0] c, input int lim, output int cnt);
    cnt = 0;
    while (ref_code_out !== c && cnt < lim) begin
      @(negedge clk_in);
      cnt++;
    end
  endtask
  function automatic int per_code(input int s);
    return 1600 >> s;
  endfunction
  function automatic logic [11:0] mv(input logic [7:0] c);
    return (c == 8'h00) ? 12'h000 :
      {2'h0, pos_pkg::VID_BASE_MV} + 12'(c - 8'h01) * {2'h0, pos_pkg::VID_STEP_MV};
  endfunction
  // Management-mode millisecond delays and ramps exceed the run budget and are not timed here
  initial begin
    logic [10:0] f;
    logic [10:0] fv [4] = '{11'h0FB, 11'h3D2, 11'h064, 11'h7D0};
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    vin_on_cmp_in <= 1'b1;
    vin_off_cmp_in <= 1'b1;
    rdchk(pos_pkg::ADDR_CTRL, 32'h101);
    rdchk(pos_pkg::ADDR_TON, 32'h0A00);
    rdchk(pos_pkg::ADDR_UNDERVOLTAGE_LOCKOUT, 32'h3840);
    rdchk(pos_pkg::ADDR_FREQ, 32'h258);
    chk(prot_armed_out, 1'b1);
    r = $random(seed);
    apb(1'b1, pos_pkg::ADDR_UNDERVOLTAGE_LOCKOUT, {16'h0, r[15:0]});
    repeat (2) @(negedge clk_in);
    chk({vin_off_thr_out, vin_on_thr_out}, r[15:0]);
    for (int i = 0; i < 5; i++) begin
      r = $random(seed);
      f = (i < 4) ? fv[i] : 11'h096 + 11'(r[9:0]);
      apb(1'b1, pos_pkg::ADDR_FREQ, {21'h0, f});
      f = (f < pos_pkg::FREQ_MIN) ? pos_pkg::FREQ_MIN :
          (f > pos_pkg::FREQ_MAX) ? pos_pkg::FREQ_MAX : f;
      rdchk(pos_pkg::ADDR_FREQ, {21'h0, f});
      chk(freq_khz_out, f);
    end
    apb(1'b1, pos_pkg::ADDR_STAT, 32'hFFFF);
    chk(err, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, pos_pkg::ADDR_CTRL, 32'h121);
    apb(1'b1, pos_pkg::ADDR_VID, 32'h5);
    drive(1'b1, 1'b0);
    repeat (50) @(negedge clk_in);
    chk(drv_en_out, 1'b0);
    drive(1'b1, 1'b1);
    repeat (8) @(negedge clk_in);
    chk(drv_en_out, 1'b1);
    repeat (40) @(negedge clk_in);
    chk(ls_en_out, 1'b0);
    @(posedge clk_in);
    hs_pulse_in <= 1'b1;
    @(posedge clk_in);
    hs_pulse_in <= 1'b0;
    // Sampled mid-step so the phase of the switching strobe does not matter
    for (int k = 0; k < 8; k++) begin
      repeat (k == 0 ? 32 : 64) @(negedge clk_in);
      chk({ls_en_out, ls_eighths_out}, {1'b1, 3'(k + 1)});
    end
    wait_code(8'h05, 3000, n);
    chk(ref_mv_out, mv(8'h05));
    chk(vin_telemetry_out, adc_prev);
    chk(drv_en_out, 1'b1);
    drive(1'b0, 1'b1);
    repeat (3) @(negedge clk_in);
    chk({drv_en_out, ls_en_out}, 2'b00);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, pos_pkg::ADDR_CTRL, 32'h21 | (s << 7));
      apb(1'b1, pos_pkg::ADDR_VID, 32'h2);
      drive(1'b1, 1'b1);
      wait_code(8'h02, 4 * per_code(s), n);
      chk(32'(n > per_code(s) && n <= 3 * per_code(s)), 32'h1);
      drive(1'b0, 1'b1);
      repeat (4) @(negedge clk_in);
    end
    apb(1'b1, pos_pkg::ADDR_CTRL, 32'h121);
    apb(1'b1, pos_pkg::ADDR_VID, 32'h0);
    drive(1'b1, 1'b1);
    repeat (1000) @(negedge clk_in);
    chk(ref_code_out, 8'h00);
    r = $random(seed);
    @(posedge clk_in);
    host_code <= 8'h01 + 8'(r[1:0]);
    host_lat <= r[7:4];
    host_req <= 1'b1;
    @(posedge clk_in);
    host_req <= 1'b0;
    wait_code(host_code, 3000, n);
    chk({ref_code_out, ref_mv_out}, {host_code, mv(host_code)});
    drive(1'b0, 1'b1);
    apb(1'b1, pos_pkg::ADDR_VID, 32'h3);
    apb(1'b1, pos_pkg::ADDR_CTRL, 32'h1AA);
    repeat (20) @(negedge clk_in);
    chk(drv_en_out, 1'b0);
    apb(1'b1, pos_pkg::ADDR_CTRL, 32'h1AE);
    repeat (4) @(negedge clk_in);
    chk(drv_en_out, 1'b1);
    apb(1'b1, pos_pkg::ADDR_CTRL, 32'h1A8);
    repeat (4) @(negedge clk_in);
    chk(drv_en_out, 1'b0);
    apb(1'b1, pos_pkg::ADDR_TOFF, 32'h105);
    apb(1'b1, pos_pkg::ADDR_CTRL, 32'h1D1);
    apb(1'b1, pos_pkg::ADDR_VID, 32'h2);
    drive(1'b1, 1'b1);
    wait_code(8'h02, 4000, n);
    chk(ref_code_out, 8'h02);
    drive(1'b0, 1'b1);
    repeat (100) @(negedge clk_in);
    chk(drv_en_out, 1'b1);
    wait_code(8'h00, 5000, n);
    chk(32'(n >= 1400 && n < 3500), 32'h1);
    repeat (4) @(negedge clk_in);
    chk(drv_en_out, 1'b0);
    apb(1'b1, pos_pkg::ADDR_TON, 32'h101);
    apb(1'b1, pos_pkg::ADDR_CTRL, 32'h101);
    drive(1'b1, 1'b1);
    repeat (200) @(negedge clk_in);
    chk(drv_en_out, 1'b0);
    rdchk(pos_pkg::ADDR_STAT, 32'h00080001);
    tally_and_finish();
  end
endmodule
